/* sleep_gating_reset_control.sv */
// sleep mode, brown-out sleep-off, clock gating and reset stretching
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ns
module sleep_gating_reset_control #(
  parameter logic [31:0] RESET_TIMEOUT_CYCLES = 32'h0001_0000
) (
  // clock, reset, enable
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       ce_i,
  // register link
  sleep_reset_if.device   link,
  // reset sources
  input  wire logic       power_on_detect_i,
  input  wire logic       ext_reset_pin_n_i,
  input  wire logic       watchdog_expired_i,
  input  wire logic       watchdog_reset_mode_i,
  input  wire logic       brownout_detect_i,
  input  wire logic       brownout_detector_enable_i,
  input  wire logic       jtag_reset_reg_i,
  input  wire logic [1:0] startup_time_fuses_i,
  input  wire logic [3:0] clock_select_fuses_i,
  // system side
  input  wire logic       wake_i,
  input  wire logic       timer_two_async_select_i,
  input  wire logic       comparator_mux_req_i,
  output logic            internal_reset_o,
  output logic            port_reset_o,
  output logic            run_start_o,
  output logic [2:0]      sleep_mode_o,
  output logic            brownout_off_o,
  output logic [7:0]      periph_clk_en_o,
  output logic            comparator_mux_en_o
);
  import sleep_reset_pkg::*;

  typedef struct packed {
    logic [1:0]  release_sync;
    logic [31:0] count;
    logic        wdt_prev;
    logic        wdt_pulse;
    logic        start;
    logic [3:0]  control;
    logic [7:0]  system_other;
    logic [2:0]  window;
    logic [2:0]  off_count;
    logic [7:0]  power_reduction;
    logic        sleeping;
    logic [2:0]  mode;
    logic        bod_off;
    logic [7:0]  clk_en;
    logic        mux_en;
    logic [7:0]  rdata;
    logic        rvalid;
  } state_type;

  state_type st;
  state_type next_st;
  logic      raw_reset;
  logic      in_reset;
  logic      off_active;
  logic [31:0] timeout;

  // every source but the watchdog asserts reset at once, with or without a clock
  assign raw_reset = ~resetn_i | power_on_detect_i | ~ext_reset_pin_n_i
                   | (brownout_detect_i & brownout_detector_enable_i) | jtag_reset_reg_i;
  assign port_reset_o = raw_reset;
  assign in_reset = ~st.release_sync[1] | st.wdt_pulse | (st.count != 32'h0000_0000);
  assign internal_reset_o = raw_reset | in_reset;
  // bit reads one from set; only the last three cycles of its life disable the detector
  assign off_active = (st.off_count != 3'h0) && (st.off_count <= SLEEP_OFF_LIFE);

  // longer start-up fuses give longer stretch; slow clock sources double it
  always_comb begin
    timeout = RESET_TIMEOUT_CYCLES >> (2'h3 - startup_time_fuses_i);
    if (clock_select_fuses_i[3]) begin
      timeout = {timeout[30:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    next_st.release_sync = {st.release_sync[0], 1'b1};
    next_st.start = 1'b0;
    next_st.rvalid = 1'b0;
    // watchdog edge gives a one-cycle reset pulse that reloads the delay counter
    next_st.wdt_prev = watchdog_expired_i;
    next_st.wdt_pulse = watchdog_expired_i & ~st.wdt_prev & watchdog_reset_mode_i;
    // delay counter loads in the two cycles after a source releases, or on the watchdog pulse, then runs down
    if (!st.release_sync[1] || st.wdt_pulse) begin
      next_st.count = timeout;
    end else if (st.count != 32'h0000_0000) begin
      next_st.count = st.count - 32'h0000_0001;
      next_st.start = (st.count == 32'h0000_0001);
    end
    if (st.window != 3'h0) begin
      next_st.window = st.window - 3'h1;
    end
    if (st.off_count != 3'h0) begin
      next_st.off_count = st.off_count - 3'h1;
    end
    if (in_reset) begin
      // registers held at initial values for the whole stretch
      next_st.control = RESET_VALUE[3:0];
      next_st.system_other = RESET_VALUE;
      next_st.power_reduction = RESET_VALUE;
      next_st.window = 3'h0;
      next_st.off_count = 3'h0;
      next_st.sleeping = 1'b0;
      next_st.bod_off = 1'b0;
    end else begin
      if (link.wr_en) begin
        case (link.addr)
          ADDR_SLEEP_MODE_CONTROL: next_st.control = link.wdata[3:0];
          ADDR_SYSTEM_CONTROL: begin
            next_st.system_other = link.wdata & 8'h9F;
            // the off bit is only reachable through the unlock window
            if (link.wdata[BROWNOUT_SLEEP_OFF] && link.wdata[BROWNOUT_SLEEP_UNLOCK]) begin
              next_st.window = UNLOCK_WINDOW;
            end else begin
              next_st.window = 3'h0;
              if (link.wdata[BROWNOUT_SLEEP_OFF] && st.window != 3'h0) begin
                next_st.off_count = SLEEP_OFF_DELAY + SLEEP_OFF_LIFE;
              end
            end
          end
          ADDR_POWER_REDUCTION: next_st.power_reduction = link.wdata;
          default: ;
        endcase
      end
      // sleep only with the gate bit and a defined mode
      if (link.sleep_instr && st.control[SLEEP_GATE_BIT] && !st.sleeping
          && st.control[MODE_MSB:MODE_LSB] != MODE_RESERVED_A
          && st.control[MODE_MSB:MODE_LSB] != MODE_RESERVED_B) begin
        next_st.sleeping = 1'b1;
        next_st.mode = st.control[MODE_MSB:MODE_LSB];
        next_st.bod_off = off_active;
      end else if (st.sleeping && wake_i) begin
        next_st.sleeping = 1'b0;
        next_st.bod_off = 1'b0;
      end
    end
    if (link.rd_en) begin
      next_st.rvalid = 1'b1;
      case (link.addr)
        ADDR_SLEEP_MODE_CONTROL: next_st.rdata = {4'h0, st.control};
        ADDR_SYSTEM_CONTROL: next_st.rdata = st.system_other
          | ({7'h00, st.off_count != 3'h0} << BROWNOUT_SLEEP_OFF)
          | ({7'h00, st.window != 3'h0} << BROWNOUT_SLEEP_UNLOCK);
        ADDR_POWER_REDUCTION: next_st.rdata = st.power_reduction;
        default: next_st.rdata = 8'h00;
      endcase
    end
    // a stopped clock freezes the peripheral in place, so it resumes from there
    next_st.clk_en = ~next_st.power_reduction;
    next_st.clk_en[GATE_TIMER_TWO] = ~(next_st.power_reduction[GATE_TIMER_TWO]
                                       & ~timer_two_async_select_i);
    next_st.mux_en = comparator_mux_req_i & link.adc_enabled
                   & ~next_st.power_reduction[GATE_CONVERTER];
  end

  // all state is cleared by any reset source but the watchdog, no clock needed
  always_ff @(posedge clk_i or posedge raw_reset) begin
    if (raw_reset) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign run_start_o = st.start;
  assign sleep_mode_o = st.mode;
  assign brownout_off_o = st.bod_off;
  assign periph_clk_en_o = st.clk_en;
  assign comparator_mux_en_o = st.mux_en;
  assign link.rdata = st.rdata;
  assign link.rvalid = st.rvalid;
  assign link.sleeping = st.sleeping;
endmodule : sleep_gating_reset_control

/* sleep_reset_pkg.sv */
// constants shared by the sleep and reset controller and its software-side end
//
// How it works
// - mode field bits 3..1 picks sleep mode
// - sleep instruction sleeps only with gate bit set
// - software sets gate before sleep, clears after
// - two-write unlock within four cycles sets sleep-off
// - sleep-off takes effect three cycles after set
// - sleep-off clears itself after three cycles
// - detector off only if sleep while sleep-off active
// - power reduction bit stops its peripheral clock
// - timer two gated only in synchronous mode
// - re-enabled timers resume from frozen state
// - software reinitialises serial modules after re-enable
// - software disables converter before gating it
// - comparator loses converter mux while gated
// - reset loads registers, then start at vector
// - ports reset at once, no clock needed; a watchdog reset never asserts port_reset_o
// - delay counter stretches reset, fuse-selected period
// - internal reset merges five sources
// - long external low resets without clock
// - power-on assertion resets immediately, delay on release
// - watchdog expiry resets in reset mode
// - scan-chain reset bit holds reset while one
// - brown-out asserts at once, timeout on release
// - watchdog gives one-cycle pulse, fall starts counter
package sleep_reset_pkg;
  // device register offsets
  localparam logic [7:0] ADDR_SLEEP_MODE_CONTROL = 8'h33;
  localparam logic [7:0] ADDR_SYSTEM_CONTROL     = 8'h35;
  localparam logic [7:0] ADDR_POWER_REDUCTION    = 8'h64;
  localparam logic [7:0] RESET_VALUE             = 8'h00;
  // field positions
  localparam int SLEEP_GATE_BIT         = 0;
  localparam int MODE_LSB               = 1;
  localparam int MODE_MSB               = 3;
  localparam int BROWNOUT_SLEEP_OFF     = 6;
  localparam int BROWNOUT_SLEEP_UNLOCK  = 5;
  localparam int GATE_TWO_WIRE          = 7;
  localparam int GATE_TIMER_TWO         = 6;
  localparam int GATE_TIMER_ZERO        = 5;
  localparam int GATE_USART_ONE         = 4;
  localparam int GATE_TIMER_ONE         = 3;
  localparam int GATE_SERIAL_PERIPH     = 2;
  localparam int GATE_USART_ZERO        = 1;
  localparam int GATE_CONVERTER         = 0;
  localparam logic [7:0] REINIT_MASK    = 8'h96;
  localparam logic [7:0] CONTROL_MASK   = 8'h0F;
  // sleep mode codes
  localparam logic [2:0] MODE_IDLE         = 3'h0;
  localparam logic [2:0] MODE_NOISE_REDUCE = 3'h1;
  localparam logic [2:0] MODE_POWER_DOWN   = 3'h2;
  localparam logic [2:0] MODE_POWER_SAVE   = 3'h3;
  localparam logic [2:0] MODE_RESERVED_A   = 3'h4;
  localparam logic [2:0] MODE_RESERVED_B   = 3'h5;
  localparam logic [2:0] MODE_STANDBY      = 3'h6;
  localparam logic [2:0] MODE_EXT_STANDBY  = 3'h7;
  // timed sequence, in clock cycles
  localparam logic [2:0] UNLOCK_WINDOW    = 3'h4;
  localparam logic [2:0] SLEEP_OFF_DELAY  = 3'h3;
  localparam logic [2:0] SLEEP_OFF_LIFE   = 3'h3;
  // software-side register words (byte addresses)
  localparam logic [3:0] HOST_ACCESS = 4'h0;
  localparam logic [3:0] HOST_SLEEP  = 4'h4;
  localparam logic [3:0] HOST_STATUS = 4'h8;
  localparam logic [3:0] HOST_ADC    = 4'hC;
  localparam int ACCESS_READ_BIT = 16;
  localparam int SLEEP_BOD_BIT   = 4;
endpackage : sleep_reset_pkg

/* sleep_reset_if.sv */
// register and sleep link between the controller and its software side
`timescale 1ns/1ns
interface sleep_reset_if;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;
  logic       sleep_instr;
  logic       sleeping;
  logic       adc_enabled;
  modport device (input wr_en, rd_en, addr, wdata, sleep_instr, adc_enabled,
                  output rdata, rvalid, sleeping);
  modport host   (output wr_en, rd_en, addr, wdata, sleep_instr, adc_enabled,
                  input rdata, rvalid, sleeping);
endinterface : sleep_reset_if

/* sleep_reset_host.sv */
// software-side end: runs register, sleep and gating sequences on AHB-Lite orders
`timescale 1ns/1ns
module sleep_reset_host (
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        hready,
  // link to the controller
  sleep_reset_if.host      link,
  // module reinitialisation requests
  output logic [7:0]       reinit_req_o
);
  import sleep_reset_pkg::*;

  typedef enum {H_IDLE, H_WRITE, H_READ, H_READ_WAIT, H_ARM, H_UNLOCK, H_SET, H_WAIT,
                H_SLEEP, H_ASLEEP, H_CLEAR} step_type;

  typedef struct packed {
    step_type    step;
    logic        dphase;
    logic        dwrite;
    logic [3:0]  daddr;
    logic [31:0] hrdata;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [2:0]  mode;
    logic        brownout_detector;
    logic [2:0]  wait_count;
    logic        adc_en;
    logic [7:0]  gates;
    logic [7:0]  reinit;
  } state_type;

  state_type st;
  state_type next_st;
  logic      busy;

  assign busy = (st.step != H_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    next_st.reinit = 8'h00;
    // zero-wait slave: address phase captured, read data loaded for the data phase
    next_st.dphase = hsel & htrans[1] & hready;
    if (hsel && htrans[1] && hready) begin
      next_st.dwrite = hwrite;
      next_st.daddr = haddr[3:0];
      case (haddr[3:0])
        HOST_STATUS: next_st.hrdata = {20'h0_0000, busy, link.sleeping, st.adc_en, st.brownout_detector,
                                       st.rdata};
        HOST_ADC:    next_st.hrdata = {31'h0000_0000, st.adc_en};
        default:     next_st.hrdata = 32'h0000_0000;
      endcase
    end
    if (st.dphase && st.dwrite && !busy) begin
      case (st.daddr)
        HOST_ACCESS: begin
          next_st.addr = hwdata[15:8];
          next_st.wdata = hwdata[7:0];
          next_st.step = hwdata[ACCESS_READ_BIT] ? H_READ : H_WRITE;
          // converter is switched off before its clock is gated
          if (!hwdata[ACCESS_READ_BIT] && hwdata[15:8] == ADDR_POWER_REDUCTION
              && hwdata[GATE_CONVERTER]) begin
            next_st.adc_en = 1'b0;
          end
        end
        HOST_SLEEP: begin
          next_st.mode = hwdata[MODE_MSB:MODE_LSB];
          next_st.brownout_detector = hwdata[SLEEP_BOD_BIT];
          // without go the instruction goes out with the gate bit still clear
          next_st.step = hwdata[SLEEP_GATE_BIT] ? H_ARM : H_SLEEP;
        end
        HOST_ADC: next_st.adc_en = hwdata[0];
        default: ;
      endcase
    end
    case (st.step)
      H_IDLE: ;
      H_WRITE: begin
        next_st.step = H_IDLE;
        if (st.addr == ADDR_POWER_REDUCTION) begin
          next_st.gates = st.wdata;
          next_st.reinit = st.gates & ~st.wdata & REINIT_MASK;
        end
      end
      H_READ: next_st.step = H_READ_WAIT;
      H_READ_WAIT: begin
        if (link.rvalid) begin
          next_st.rdata = link.rdata;
          next_st.step = H_IDLE;
        end
      end
      H_ARM: next_st.step = st.brownout_detector ? H_UNLOCK : H_SLEEP;
      H_UNLOCK: next_st.step = H_SET;
      H_SET: begin
        next_st.step = H_WAIT;
        next_st.wait_count = SLEEP_OFF_DELAY;
      end
      // sleep lands inside the window where the off bit is effective
      H_WAIT: begin
        next_st.wait_count = st.wait_count - 3'h1;
        if (st.wait_count == 3'h1) begin
          next_st.step = H_SLEEP;
        end
      end
      H_SLEEP: next_st.step = H_ASLEEP;
      H_ASLEEP: begin
        if (!link.sleeping) begin
          next_st.step = H_CLEAR;
        end
      end
      H_CLEAR: next_st.step = H_IDLE;
      default: next_st.step = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '{step: H_IDLE, default: '0};
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    link.wr_en = 1'b0;
    link.rd_en = 1'b0;
    link.addr = st.addr;
    link.wdata = st.wdata;
    link.sleep_instr = 1'b0;
    case (st.step)
      H_WRITE: link.wr_en = 1'b1;
      H_READ: link.rd_en = 1'b1;
      H_ARM, H_CLEAR: begin
        link.wr_en = 1'b1;
        link.addr = ADDR_SLEEP_MODE_CONTROL;
        link.wdata = {4'h0, st.mode, st.step == H_ARM};
      end
      H_UNLOCK, H_SET: begin
        link.wr_en = 1'b1;
        link.addr = ADDR_SYSTEM_CONTROL;
        link.wdata = 8'h00;
        link.wdata[BROWNOUT_SLEEP_OFF] = 1'b1;
        link.wdata[BROWNOUT_SLEEP_UNLOCK] = (st.step == H_UNLOCK);
      end
      H_SLEEP: link.sleep_instr = 1'b1;
      default: ;
    endcase
  end

  assign link.adc_enabled = st.adc_en;
  assign hrdata = st.hrdata;
  assign hreadyout = ce_i;
  assign hresp = 1'b0;
  assign reinit_req_o = st.reinit;
endmodule : sleep_reset_host

/* sleep_reset_properties.sv */
// link-side assertions for the sleep and reset controller
`timescale 1ns/1ns
module sleep_reset_properties
  import sleep_reset_pkg::*;
(
  // clock and resets
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic       internal_reset_o,
  // link
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  input wire logic       sleep_instr,
  input wire logic       sleeping
);
  logic [7:0] mode_reg;
  logic [7:0] gate_reg;
  logic       rsv;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i || internal_reset_o);
  assign rsv = (mode_reg[3:1] == MODE_RESERVED_A) || (mode_reg[3:1] == MODE_RESERVED_B);
  ////////////////////////////////////////////////////////////
  // shadows; the device drops its own copies during internal reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_reg <= RESET_VALUE;
      gate_reg <= RESET_VALUE;
    end else if (internal_reset_o) begin
      mode_reg <= RESET_VALUE;
      gate_reg <= RESET_VALUE;
    end else if (wr_en && addr == ADDR_SLEEP_MODE_CONTROL) begin
      mode_reg <= wdata & CONTROL_MASK;
    end else if (wr_en && addr == ADDR_POWER_REDUCTION) begin
      gate_reg <= wdata;
    end
  end
  ////////////////////////////////////////////////////////////
  read_answer_a: assert property (rd_en |=> rvalid)
    else $error("read not answered");
  answer_cause_a: assert property (rvalid |-> $past(rd_en))
    else $error("answer without read");
  upper_bits_a: assert property (
    rvalid && $past(addr) == ADDR_SLEEP_MODE_CONTROL |-> rdata[7:4] == 4'h0)
    else $error("upper control bits not zero");
  mode_read_a: assert property (
    rd_en && addr == ADDR_SLEEP_MODE_CONTROL |=> rdata == mode_reg)
    else $error("mode control readback wrong");
  gate_read_a: assert property (
    rd_en && addr == ADDR_POWER_REDUCTION |=> rdata == gate_reg)
    else $error("power reduction readback wrong");
  sleep_refused_a: assert property (
    sleep_instr && !sleeping && !mode_reg[0] |=> !sleeping [*2])
    else $error("slept with gate bit clear");
  reserved_mode_a: assert property (sleep_instr && !sleeping && rsv |=> !sleeping)
    else $error("slept in reserved mode");
  sleep_taken_a: assert property (
    sleep_instr && !sleeping && mode_reg[0] && !rsv |=> sleeping)
    else $error("sleep not entered");
  sleep_cause_a: assert property ($rose(sleeping) |-> $past(sleep_instr))
    else $error("sleep without instruction");
endmodule : sleep_reset_properties

/* sleep_gating_reset_control_tb.sv */
// self-checking bench: both ends joined, driven over AHB-Lite and reset sources
`timescale 1ns/1ns
module sleep_gating_reset_control_tb;
  import sleep_reset_pkg::*;
  localparam int STRETCH = 16;
  logic clk_i = 1'b0, resetn_i = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
  logic por = 1'b0, pin_n = 1'b1, wdog = 1'b0, wdog_mode = 1'b1, brown_det = 1'b0;
  logic brown_en = 1'b1, jtag = 1'b0, wake = 1'b0, async_sel = 1'b0, mux_req = 1'b0, ce = 1'b1;
  logic int_rst, port_rst, run_start, brown_off, mux_en;
  logic [2:0] sleep_mode;
  logic [7:0] clk_en, reinit, reinit_last;
  int err_total = 0, cmp_count = 0, starts = 0, reinit_n = 0;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (run_start === 1'b1) starts++;
    if (|reinit) begin
      reinit_n++;
      reinit_last = reinit;
    end
  end
  sleep_reset_if u_sleep_reset_if ();
  sleep_gating_reset_control #(
    .RESET_TIMEOUT_CYCLES(32'h0000_0010)
  ) u_sleep_gating_reset_control (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce), .link(u_sleep_reset_if.device),
    .power_on_detect_i(por), .ext_reset_pin_n_i(pin_n), .watchdog_expired_i(wdog),
    .watchdog_reset_mode_i(wdog_mode), .brownout_detect_i(brown_det),
    .brownout_detector_enable_i(brown_en), .jtag_reset_reg_i(jtag),
    .startup_time_fuses_i(2'h3), .clock_select_fuses_i(4'h0), .wake_i(wake),
    .timer_two_async_select_i(async_sel), .comparator_mux_req_i(mux_req),
    .internal_reset_o(int_rst), .port_reset_o(port_rst), .run_start_o(run_start),
    .sleep_mode_o(sleep_mode), .brownout_off_o(brown_off), .periph_clk_en_o(clk_en),
    .comparator_mux_en_o(mux_en));
  sleep_reset_host u_sleep_reset_host (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .hready(hreadyout),
    .link(u_sleep_reset_if.host), .reinit_req_o(reinit));
  sleep_reset_properties u_sleep_reset_properties (
    .clk_i(clk_i), .resetn_i(resetn_i), .internal_reset_o(int_rst),
    .wr_en(u_sleep_reset_if.wr_en), .rd_en(u_sleep_reset_if.rd_en),
    .addr(u_sleep_reset_if.addr), .wdata(u_sleep_reset_if.wdata),
    .rdata(u_sleep_reset_if.rdata), .rvalid(u_sleep_reset_if.rvalid),
    .sleep_instr(u_sleep_reset_if.sleep_instr), .sleeping(u_sleep_reset_if.sleeping));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge clk_i); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_i); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  // commands are not queued, so every one waits for busy to drop
  task automatic idle(output logic [31:0] s);
    do ahb(1'b0, HOST_STATUS, 32'h0000_0000, s); while (s[11] !== 1'b0);
  endtask : idle
  task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] s;
    ahb(1'b1, HOST_ACCESS, {16'h0000, a, d}, s);
    idle(s);
  endtask : dev_wr
  task automatic dev_rd(input logic [7:0] a, output logic [7:0] v);
    logic [31:0] s;
    ahb(1'b1, HOST_ACCESS, {15'h0000, 1'b1, a, 8'h00}, s);
    idle(s);
    v = s[7:0];
  endtask : dev_rd
  ////////////////////////////////////////////////////////////
  task automatic sleep_run(input logic [2:0] m, input logic off, input logic go);
    logic [31:0] s;
    logic [7:0] v;
    logic ok;
    ok = go && (m != MODE_RESERVED_A) && (m != MODE_RESERVED_B);
    ahb(1'b1, HOST_SLEEP, {27'h000_0000, off, m, go}, s);
    for (int i = 0; i < 40 && u_sleep_reset_if.sleeping !== 1'b1; i++) @(posedge clk_i);
    chk(u_sleep_reset_if.sleeping, ok);
    if (ok) begin
      chk({sleep_mode, brown_off}, {m, off});
      ahb(1'b0, HOST_STATUS, 32'h0000_0000, s);
      chk({s[10], s[8]}, {1'b1, off});
      wake <= 1'b1;
      @(posedge clk_i);
      wake <= 1'b0;
      idle(s);
      chk({u_sleep_reset_if.sleeping, brown_off}, 2'h0);
      dev_rd(ADDR_SLEEP_MODE_CONTROL, v);
      chk(v, {4'h0, m, 1'b0});
    end
    idle(s);
  endtask : sleep_run
  task automatic gate_test;
    logic [31:0] s;
    logic [7:0] v, e, r;
    int n0;
    mux_req <= 1'b1;
    for (int a = 0; a < 2; a++) begin
      for (int b = 0; b < 8; b++) begin
        v = 8'h01 << b;
        async_sel <= a[0];
        // the host drops the converter before gating it, so re-arm it each pass
        ahb(1'b1, HOST_ADC, 32'h0000_0001, s);
        dev_wr(ADDR_POWER_REDUCTION, v);
        e = ~v;
        e[6] = e[6] | a[0];
        chk(clk_en, e);
        chk(mux_en, !v[0]);
        ahb(1'b0, HOST_STATUS, 32'h0000_0000, s);
        chk(s[9], !v[0]);
        dev_rd(ADDR_POWER_REDUCTION, r);
        chk(r, v);
        n0 = reinit_n;
        dev_wr(ADDR_POWER_REDUCTION, 8'h00);
        chk(clk_en, 8'hFF);
        chk(reinit_n - n0, |(v & REINIT_MASK));
        if (|(v & REINIT_MASK)) chk(reinit_last, v & REINIT_MASK);
      end
    end
    ahb(1'b1, HOST_ADC, 32'h0000_0000, s);
    idle(s);
    chk(mux_en, 1'b0);
  endtask : gate_test
  // a low enable must hold every register even while a gating input moves
  task automatic freeze_test;
    async_sel <= 1'b0;
    dev_wr(ADDR_POWER_REDUCTION, 8'h40);
    chk(clk_en, 8'hBF);
    ce <= 1'b0;
    async_sel <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({hreadyout, clk_en}, {1'b0, 8'hBF});
    ce <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(clk_en, 8'hFF);
    async_sel <= 1'b0;
    dev_wr(ADDR_POWER_REDUCTION, 8'h00);
  endtask : freeze_test
  task automatic rst_src(input int k, input logic fire);
    logic [7:0] v;
    int n, s0;
    dev_wr(ADDR_POWER_REDUCTION, 8'h3C);
    s0 = starts;
    case (k)
      0: por <= 1'b1;
      1: pin_n <= 1'b0;
      2: brown_det <= 1'b1;
      3: jtag <= 1'b1;
      default: wdog <= 1'b1;
    endcase
    #1;
    if (k < 4) chk({int_rst, port_rst}, {fire, fire});
    @(posedge clk_i);
    {por, pin_n, brown_det, jtag, wdog} <= 5'b01000;
    #1;
    chk(int_rst, fire);
    n = 0;
    while (int_rst !== 1'b0 && n < 80) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (fire) begin
      chk(n >= STRETCH && n <= STRETCH + 6, 1'b1);
      dev_rd(ADDR_POWER_REDUCTION, v);
      chk(v, RESET_VALUE);
      chk(starts - s0, 1);
    end
  endtask : rst_src
  ////////////////////////////////////////////////////////////
  initial begin
    #300000;
    err_total++;
    $display("BAD %0t run did not finish", $time);
    wrap_up();
  end
  initial begin
    logic [31:0] s;
    logic [7:0] v;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 200 && int_rst !== 1'b0; i++) @(posedge clk_i);
    ahb(1'b0, 8'h10, 32'h0000_0000, s);
    chk(s, 32'h0000_0000);
    dev_wr(ADDR_SLEEP_MODE_CONTROL, 8'hFF);
    dev_rd(ADDR_SLEEP_MODE_CONTROL, v);
    chk(v, 8'h0F);
    for (int m = 0; m < 8; m++) begin
      dev_wr(ADDR_SYSTEM_CONTROL, 8'h40);
      dev_rd(ADDR_SYSTEM_CONTROL, v);
      chk(v[BROWNOUT_SLEEP_OFF], 1'b0);
      sleep_run(m[2:0], 1'b0, 1'b1);
    end
    sleep_run(MODE_POWER_DOWN, 1'b1, 1'b1);
    sleep_run(MODE_EXT_STANDBY, 1'b1, 1'b1);
    sleep_run(MODE_POWER_DOWN, 1'b0, 1'b0);
    dev_rd(ADDR_SYSTEM_CONTROL, v);
    chk(v[BROWNOUT_SLEEP_OFF], 1'b0);
    gate_test();
    freeze_test();
    for (int k = 0; k < 5; k++) rst_src(k, 1'b1);
    brown_en <= 1'b0;
    wdog_mode <= 1'b0;
    rst_src(2, 1'b0);
    rst_src(4, 1'b0);
    wrap_up();
  end
endmodule : sleep_gating_reset_control_tb
